// ===== verilog/dpd_host.sv
// Purpose: host that drives one memory controller port from Wishbone registers
// Assumes: the port's clock is SYS_CLK; request bits sampled on SYS_CLK
// Notes: one burst at a time; write beats repeat the pattern register
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module dpd_host
#(
  parameter int DATA_W = 256 // 256 for port 0, 128 for port 1
)
(
  input wire logic SYS_CLK, // system and port clock
  input wire logic RESET, // async reset, active high
  input wire logic [7:0] WB_ADR_I, // byte address
  input wire logic [31:0] WB_DAT_I, // write data
  output logic [31:0] WB_DAT_O, // read data
  input wire logic [3:0] WB_SEL_I, // byte lanes
  input wire logic WB_WE_I, // write enable
  input wire logic WB_STB_I, // strobe
  input wire logic WB_CYC_I, // cycle
  output logic WB_ACK_O, // acknowledge
  output logic SHARED_REQ_PRESENT, // request valid
  input wire logic SHARED_REQ_ACCEPT, // request ready
  output logic SHARED_REQ_DIRECTION, // 0 read, 1 write
  output logic [31:0] SHARED_REQ_ADDRESS, // first beat address
  output logic [7:0] SHARED_REQ_TAG, // request tag
  output logic [7:0] SHARED_REQ_BEAT_COUNT, // beats minus one
  output logic [1:0] SHARED_REQ_BURST_TYPE, // burst type
  output logic [2:0] SHARED_REQ_BEAT_SIZE, // beat size code
  output logic [1:0] SHARED_REQ_ATOMIC, // lock type
  output logic [DATA_W-1:0] WDATA, // write data
  output logic [DATA_W/8-1:0] WSTRB, // byte strobes
  output logic [7:0] WID, // write tag
  output logic WLAST, // last write beat
  output logic WVALID, // write valid
  input wire logic WREADY, // write ready
  input wire logic [7:0] BID, // response tag
  input wire logic BVALID, // response valid
  output logic BREADY, // response ready
  input wire logic [DATA_W-1:0] RDATA, // read data
  input wire logic [7:0] RID, // read tag
  input wire logic [1:0] RRESP, // read status
  input wire logic RLAST, // last read beat
  input wire logic RVALID, // read valid
  output logic RREADY, // read ready
  output logic INIT_SEQUENCER_RESET, // setup sequencer reset, high
  output logic INIT_SEQUENCER_GO, // setup sequencer start
  output logic MEM_RESET_N // master memory reset, low
);
  import dpd_pkg::*;

  localparam int STRB_W = DATA_W / 8;

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  // only the two documented port widths exist
  if (DATA_W != 128 && DATA_W != 256)
  begin : g_bad_width
    $error("dpd_host: DATA_W must be 128 or 256");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    dpd_state_t st;
    logic ack;
    logic [31:0] dat;
    logic dir;
    logic [1:0] bt;
    logic [2:0] sz;
    logic [1:0] lk;
    logic [31:0] addr;
    logic [7:0] len;
    logic [7:0] tag;
    logic [31:0] pat;
    logic [31:0] strb;
    logic busy;
    logic done;
    logic err;
    logic [7:0] lid;
    logic [1:0] rsp;
    logic [31:0] rdat;
    logic [8:0] beat;
    logic seq_rst;
    logic seq_go;
    logic mem_rel;
  } dpd_regs_t;

  dpd_regs_t s_q;
  dpd_regs_t s_d;

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction : merge

  logic wb_req;
  logic init_ok;
  logic last_beat;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    s_d = s_q;
    s_d.ack = 1'h0;
    wb_req = WB_CYC_I & WB_STB_I & ~s_q.ack;
    // no access before setup is released and started
    init_ok = s_q.mem_rel & s_q.seq_go & ~s_q.seq_rst; // R23
    last_beat = (s_q.beat == {1'h0, s_q.len});

    // register access, answered one cycle after the request edge
    if (wb_req)
    begin
      s_d.ack = 1'h1;
      unique case (WB_ADR_I)
        OFS_CTRL: s_d.dat = {22'h0, s_q.lk, 1'h0, s_q.sz, s_q.bt, s_q.dir, 1'h0};
        OFS_ADDR: s_d.dat = s_q.addr;
        OFS_BURST: s_d.dat = {16'h0, s_q.tag, s_q.len};
        OFS_PAT: s_d.dat = s_q.pat;
        OFS_STRB: s_d.dat = s_q.strb;
        OFS_STAT: s_d.dat = {14'h0, s_q.rsp, s_q.lid, 5'h0, s_q.err, s_q.done, s_q.busy};
        OFS_RDAT: s_d.dat = s_q.rdat;
        OFS_INIT: s_d.dat = {29'h0, s_q.mem_rel, s_q.seq_go, s_q.seq_rst};
        default: s_d.dat = 32'h0;
      endcase
      if (WB_WE_I)
      begin
        unique case (WB_ADR_I)
          OFS_CTRL:
          begin
            // request fields frozen while a burst is in flight
            if (!s_q.busy && WB_SEL_I[0])
            begin
              s_d.dir = WB_DAT_I[CTL_DIR]; // R08
              s_d.bt = WB_DAT_I[CTL_BT +: 2];
              s_d.sz = WB_DAT_I[CTL_SZ +: 3];
              if (WB_DAT_I[CTL_GO])
              begin
                if (init_ok)
                begin
                  s_d.busy = 1'h1;
                  s_d.st = ST_ADDR;
                  s_d.rsp = RESP_OKAY;
                  s_d.beat = 9'h0;
                end
                else
                begin
                  s_d.err = 1'h1; // refused start
                end
              end
            end
            if (!s_q.busy && WB_SEL_I[1])
            begin
              s_d.lk = WB_DAT_I[CTL_LK +: 2]; // R14
            end
          end
          OFS_ADDR: if (!s_q.busy) s_d.addr = merge(s_q.addr, WB_DAT_I, WB_SEL_I);
          OFS_BURST:
          begin
            if (!s_q.busy && WB_SEL_I[0]) s_d.len = WB_DAT_I[BST_LEN +: 8]; // R11
            if (!s_q.busy && WB_SEL_I[1]) s_d.tag = WB_DAT_I[BST_TAG +: 8]; // R10
          end
          OFS_PAT: if (!s_q.busy) s_d.pat = merge(s_q.pat, WB_DAT_I, WB_SEL_I);
          OFS_STRB: if (!s_q.busy) s_d.strb = merge(s_q.strb, WB_DAT_I, WB_SEL_I);
          OFS_STAT:
          begin
            // write one to clear; a same-cycle event below wins
            if (WB_SEL_I[0] && WB_DAT_I[STA_DONE]) s_d.done = 1'h0;
            if (WB_SEL_I[0] && WB_DAT_I[STA_ERR]) s_d.err = 1'h0;
          end
          OFS_INIT:
          begin
            if (WB_SEL_I[0])
            begin
              s_d.seq_rst = WB_DAT_I[INI_SRST]; // R22
              s_d.seq_go = WB_DAT_I[INI_SGO] & ~WB_DAT_I[INI_SRST]; // R22
              s_d.mem_rel = WB_DAT_I[INI_MREL]; // R21
            end
          end
          default: s_d.dat = 32'h0;
        endcase
      end
    end

    // burst sequencing; every hop waits for valid and ready together
    unique case (s_q.st)
      ST_IDLE: s_d.beat = s_q.beat;
      ST_ADDR:
      begin
        if (SHARED_REQ_ACCEPT) // R15 R24
        begin
          s_d.st = (s_q.dir == DIR_WRITE) ? ST_WDAT : ST_RDAT; // R08
          s_d.beat = 9'h0;
        end
      end
      ST_WDAT:
      begin
        if (WREADY) // R20 R24
        begin
          s_d.beat = s_q.beat + 9'h1;
          if (last_beat)
          begin
            s_d.st = ST_WRSP;
          end
        end
      end
      ST_WRSP:
      begin
        if (BVALID) // R16 R24
        begin
          s_d.lid = BID;
          if (BID != s_q.tag) s_d.err = 1'h1; // R16
          s_d.done = 1'h1;
          s_d.busy = 1'h0;
          s_d.st = ST_IDLE;
        end
      end
      ST_RDAT:
      begin
        if (RVALID) // R17 R18 R24
        begin
          s_d.lid = RID;
          s_d.rdat = RDATA[31:0];
          s_d.rsp = s_q.rsp | RRESP; // R18
          s_d.beat = s_q.beat + 9'h1;
          // tag, status or last mark out of place flags an error
          if (RID != s_q.tag || RRESP != RESP_OKAY || RLAST != last_beat) // R17
          begin
            s_d.err = 1'h1;
          end
          if (RLAST || last_beat)
          begin
            s_d.done = 1'h1;
            s_d.busy = 1'h0;
            s_d.st = ST_IDLE;
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge SYS_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.strb <= STRB_RST;
      s_q.seq_rst <= SEQ_RST_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // wishbone answer
  assign WB_ACK_O = s_q.ack;
  assign WB_DAT_O = s_q.dat;

  // request channel, fields held from flops while present
  assign SHARED_REQ_PRESENT = (s_q.st == ST_ADDR); // R15
  assign SHARED_REQ_DIRECTION = s_q.dir; // R08
  assign SHARED_REQ_ADDRESS = s_q.addr; // R09
  assign SHARED_REQ_TAG = s_q.tag; // R10
  assign SHARED_REQ_BEAT_COUNT = s_q.len; // R11
  assign SHARED_REQ_BURST_TYPE = s_q.bt; // R12
  assign SHARED_REQ_BEAT_SIZE = s_q.sz; // R13
  assign SHARED_REQ_ATOMIC = s_q.lk; // R14

  // write beats repeat the pattern word across the bus
  assign WDATA = {(DATA_W / 32){s_q.pat}};
  assign WSTRB = s_q.strb[STRB_W-1:0]; // R19
  assign WID = s_q.tag; // R20
  assign WVALID = (s_q.st == ST_WDAT); // R20
  assign WLAST = (s_q.st == ST_WDAT) & last_beat; // R20

  // response and read acceptance
  assign BREADY = (s_q.st == ST_WRSP); // R16
  assign RREADY = (s_q.st == ST_RDAT); // R18

  // setup controls
  assign INIT_SEQUENCER_RESET = s_q.seq_rst; // R22
  assign INIT_SEQUENCER_GO = s_q.seq_go; // R22
  assign MEM_RESET_N = s_q.mem_rel; // R23

endmodule : dpd_host

`default_nettype wire

// ===== pkg/dpd_pkg.sv
// Purpose: constants and types for the memory port host controller
// Assumes: one 32-bit classic Wishbone slave, one memory port on SYS_CLK
// Notes: offsets are byte addresses of aligned 32-bit words
//
// Behaviour
// R01 - Memory controller offers port 0 at 256 bits and port 1 at 128 bits.
// R02 - Memory lanes run up to 1066 Mbps each.
// R03 - Memory data bus is 16 or 32 bits wide by package.
// R04 - Fast memory clock comes from a PLL at half the lane rate.
// R05 - Fast memory clock carries two bits per lane per period.
// R06 - All memory traffic goes through the controller, never the raw lanes.
// R07 - A calibration bus reaches the memory configuration registers.
// R08 - One request channel per port; direction 0 reads, 1 writes.
// R09 - Master presents a 32-bit start address for the burst.
// R10 - An 8-bit tag travels with each request, read or write.
// R11 - Master gives an 8-bit beat count field for the burst.
// R12 - Controller steps beat addresses from burst type and beat size.
// R13 - Master gives a 3-bit beat size with each request.
// R14 - Master gives a 2-bit atomic field with each request.
// R15 - Master raises request present; controller raises request accept.
// R16 - Each write completes with a tagged response; master accepts with ready.
// R17 - Read beats carry valid, an 8-bit tag and a last mark.
// R18 - Each read beat carries a 2-bit status; master accepts with ready.
// R19 - Master drives one strobe bit per data byte.
// R20 - Master tags write beats, raises valid, marks last; controller gives ready.
// R21 - Fabric offers a user reset that starts memory setup.
// R22 - Setup sequencer held while its reset is high, starts on go.
// R23 - After memory reset release, setup completes before any access; the host only waits for release and go, not for completion.
// R24 - A transfer happens on an edge where valid and ready are high.
package dpd_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_BURST = 8'h08;
  localparam logic [7:0] OFS_PAT = 8'h0c;
  localparam logic [7:0] OFS_STRB = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_RDAT = 8'h18;
  localparam logic [7:0] OFS_INIT = 8'h1c;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_GO = 0;
  localparam int CTL_DIR = 1;
  localparam int CTL_BT = 2;
  localparam int CTL_SZ = 4;
  localparam int CTL_LK = 8;
  localparam int BST_LEN = 0;
  localparam int BST_TAG = 8;
  localparam int STA_BUSY = 0;
  localparam int STA_DONE = 1;
  localparam int STA_ERR = 2;
  localparam int STA_ID = 8;
  localparam int STA_RSP = 16;
  localparam int INI_SRST = 0;
  localparam int INI_SGO = 1;
  localparam int INI_MREL = 2;

  // ****************************************************************
  // values
  // ****************************************************************
  localparam logic DIR_READ = 1'h0;
  localparam logic DIR_WRITE = 1'h1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [31:0] STRB_RST = 32'hffffffff;
  localparam logic SEQ_RST_RST = 1'h1;

  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WDAT, ST_WRSP, ST_RDAT} dpd_state_t;

endpackage : dpd_pkg

// ===== sim/dpd_host_properties.sv
// Purpose: timing checks on the memory port of the host
// Assumes: one clock domain, reset active high
// Notes: bound to every host instance
`timescale 1ns/1ps
`default_nettype none
module dpd_host_properties (
  input wire logic SYS_CLK, // clock
  input wire logic RESET, // reset
  input wire logic WB_ACK_O, // bus ack
  input wire logic SHARED_REQ_PRESENT, // req valid
  input wire logic SHARED_REQ_ACCEPT, // req ready
  input wire logic SHARED_REQ_DIRECTION, // direction
  input wire logic [31:0] SHARED_REQ_ADDRESS, // address
  input wire logic WVALID, // beat valid
  input wire logic WREADY, // beat ready
  input wire logic WLAST, // last beat
  input wire logic BVALID, // resp valid
  input wire logic BREADY, // resp ready
  input wire logic RVALID, // read valid
  input wire logic RREADY, // read ready
  input wire logic RLAST // last read
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // handshakes that close a phase
  sequence wr_last; WVALID && WREADY && WLAST; endsequence
  sequence rd_last; RVALID && RREADY && RLAST; endsequence
  req_start_a: assert property ($rose(SHARED_REQ_PRESENT) |-> WB_ACK_O)
    else $error("request without go");
  req_hold_a: assert property (SHARED_REQ_PRESENT && !SHARED_REQ_ACCEPT |=>
    SHARED_REQ_PRESENT && $stable(SHARED_REQ_ADDRESS) && $stable(SHARED_REQ_DIRECTION))
    else $error("request dropped early");
  req_done_a: assert property (SHARED_REQ_PRESENT && SHARED_REQ_ACCEPT |=> !SHARED_REQ_PRESENT)
    else $error("request repeated");
  wbeat_hold_a: assert property (WVALID && !WREADY |=> WVALID && $stable(WLAST))
    else $error("write beat dropped");
  wr_dir_a: assert property (WVALID || BREADY |-> SHARED_REQ_DIRECTION)
    else $error("write phase on read");
  rd_dir_a: assert property (RREADY |-> !SHARED_REQ_DIRECTION)
    else $error("read phase on write");
  resp_wait_a: assert property (wr_last |=> BREADY && !WVALID)
    else $error("no response phase");
  resp_end_a: assert property (BVALID && BREADY |=> !BREADY)
    else $error("response kept open");
  rd_end_a: assert property (rd_last |=> !RREADY ##1 !RREADY)
    else $error("read past last");
endmodule : dpd_host_properties
bind dpd_host dpd_host_properties dpd_host_properties_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .WB_ACK_O(WB_ACK_O), .SHARED_REQ_PRESENT(SHARED_REQ_PRESENT),
  .SHARED_REQ_ACCEPT(SHARED_REQ_ACCEPT), .SHARED_REQ_DIRECTION(SHARED_REQ_DIRECTION),
  .SHARED_REQ_ADDRESS(SHARED_REQ_ADDRESS), .WVALID(WVALID), .WREADY(WREADY),
  .WLAST(WLAST), .BVALID(BVALID), .BREADY(BREADY), .RVALID(RVALID), .RREADY(RREADY),
  .RLAST(RLAST));
`default_nettype wire

// ===== sim/dpd_mem_model.sv
// Purpose: memory port target seen by the host
// Assumes: one burst at a time, port clock is the bench clock
// Notes: request accept and write ready lag valid one cycle, so those handshakes wait
`timescale 1ns/1ps
`default_nettype none
module dpd_mem_model #(
  parameter int DATA_W = 256 // port width
) (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic [1:0] rsp, // read status
  input wire logic fault, // corrupt returned tags
  input wire logic present, // req valid
  input wire logic dir, // direction
  input wire logic [7:0] tag, // req tag
  input wire logic [7:0] len, // beats-1
  input wire logic wvalid, // beat valid
  input wire logic wlast, // last beat
  input wire logic bready, // resp ready
  input wire logic rready, // read ready
  output logic accept, // req ready
  output logic wready, // beat ready
  output logic bvalid, // resp valid
  output logic [7:0] bid, // resp tag
  output logic rvalid, // read valid
  output logic rlast, // last read
  output logic [7:0] rid, // read tag
  output logic [1:0] rresp, // status
  output logic [DATA_W-1:0] rdata, // read data
  output logic [7:0] beats // beats taken
);
  logic ract;
  logic [7:0] rcnt, rlen, ptag;
  // whole port in one process; idle tag and read data buses toggle so stale values never match, status and last hold
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      {ract, accept, wready, bvalid, rvalid, rlast, bid, rid, rresp} <= '0;
      {rcnt, rlen, ptag, beats, rdata} <= '0;
    end
    else
    begin
      accept <= present && !accept;
      wready <= wvalid && !wready;
      if (present && accept)
      begin
        ptag <= tag;
        rlen <= len;
        rcnt <= 8'h00;
        beats <= 8'h00;
        ract <= !dir;
      end
      if (wvalid && wready)
        beats <= beats + 8'h01;
      if (!bvalid)
        bid <= ~bid;
      if (wvalid && wready && wlast)
      begin
        bvalid <= 1'b1;
        bid <= fault ? ~ptag : ptag;
      end
      if (bvalid && bready)
        bvalid <= 1'b0;
      if (!rvalid)
      begin
        rdata <= ~rdata;
        rid <= ~rid;
      end
      if (rvalid && rready)
      begin
        rvalid <= 1'b0;
        rcnt <= rcnt + 8'h01;
        ract <= !rlast;
      end
      else if (ract && !rvalid)
      begin
        rvalid <= 1'b1;
        rlast <= rcnt == rlen;
        rid <= fault ? ~ptag : ptag;
        rresp <= rsp;
        rdata <= {(DATA_W/32){32'ha5a50000 | {24'h0, rcnt}}};
      end
    end
endmodule : dpd_mem_model
`default_nettype wire

// ===== sim/tb.sv
// Purpose: register level bench of the memory port host
// Assumes: 256-bit port, target model on the far side
// Notes: every wait is bounded
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dpd_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdo, q, addr;
  logic [3:0] sel = 4'h0;
  logic [3:0] bsel = 4'hf;
  logic fault = 1'b0;
  logic we = 1'b0, stb = 1'b0, cyc = 1'b0;
  logic [1:0] rsp = 2'h0;
  logic ack, pres, acc, dir, wlast, wvalid, wready, bvalid, bready;
  logic rlast, rvalid, rready, srst, sgo, mrn;
  logic [7:0] tag, len, wid, bid, rid, beats;
  logic [1:0] bt, atom, rresp;
  logic [2:0] bsz;
  logic [255:0] wdata, rdata;
  logic [31:0] wstrb;
  int miscompares = 0;
  int checks = 0;
  dpd_host #(.DATA_W(256)) dpd_host_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .WB_ADR_I(adr),
    .WB_DAT_I(wd), .WB_DAT_O(rdo), .WB_SEL_I(sel), .WB_WE_I(we), .WB_STB_I(stb),
    .WB_CYC_I(cyc), .WB_ACK_O(ack), .SHARED_REQ_PRESENT(pres), .SHARED_REQ_ACCEPT(acc),
    .SHARED_REQ_DIRECTION(dir), .SHARED_REQ_ADDRESS(addr), .SHARED_REQ_TAG(tag),
    .SHARED_REQ_BEAT_COUNT(len), .SHARED_REQ_BURST_TYPE(bt), .SHARED_REQ_BEAT_SIZE(bsz),
    .SHARED_REQ_ATOMIC(atom), .WDATA(wdata), .WSTRB(wstrb), .WID(wid), .WLAST(wlast),
    .WVALID(wvalid), .WREADY(wready), .BID(bid), .BVALID(bvalid), .BREADY(bready),
    .RDATA(rdata), .RID(rid), .RRESP(rresp), .RLAST(rlast), .RVALID(rvalid), .RREADY(rready),
    .INIT_SEQUENCER_RESET(srst), .INIT_SEQUENCER_GO(sgo), .MEM_RESET_N(mrn));
  dpd_mem_model #(.DATA_W(256)) dpd_mem_model_inst (.clk(SYS_CLK), .rst(RESET), .rsp(rsp),
    .fault(fault),
    .present(pres), .dir(dir), .tag(tag), .len(len), .wvalid(wvalid), .wlast(wlast),
    .bready(bready), .rready(rready), .accept(acc), .wready(wready), .bvalid(bvalid),
    .bid(bid), .rvalid(rvalid), .rlast(rlast), .rid(rid), .rresp(rresp), .rdata(rdata),
    .beats(beats));
  // 200 MHz clock
  always #2.5 SYS_CLK = ~SYS_CLK;
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [255:0] s, input logic [255:0] e);
    checks++;
    if (s !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, s);
      miscompares++;
    end
  endtask : chk
  // one classic cycle; request held until ack is sampled high
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    {cyc, stb, we, adr, wd, sel} <= {1'b1, 1'b1, w, a, d, bsel};
    while (ack !== 1'b1 && n < 40)
    begin
      @(posedge SYS_CLK);
      n++;
    end
    if (n == 40)
    begin
      miscompares++;
      summarize();
    end
    q = rdo;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    wb(a, 1'b0, 32'h0);
    chk(nm, q, e);
  endtask : rd
  // poll status until the burst has finished
  task automatic idle;
    int n;
    n = 0;
    wb(OFS_STAT, 1'b0, 32'h0);
    while (q[STA_BUSY] !== 1'b0 && n < 60)
    begin
      wb(OFS_STAT, 1'b0, 32'h0);
      n++;
    end
    if (n == 60)
    begin
      miscompares++;
      summarize();
    end
  endtask : idle
  initial
  begin
    repeat (8) @(posedge SYS_CLK);
    RESET <= 1'b0;
    chk("pins_at_reset", {srst, sgo, mrn}, 3'b100);
    rd(OFS_STRB, STRB_RST, "strb_reset");
    rd(OFS_INIT, 32'h1, "init_reset");
    wb(OFS_CTRL, 1'b1, 32'h3);
    rd(OFS_STAT, 32'h4, "early_go");
    chk("early_present", pres, 1'b0);
    wb(OFS_STAT, 1'b1, 32'h6);
    wb(OFS_INIT, 1'b1, 32'h6);
    chk("pins_ready", {srst, sgo, mrn}, 3'b011);
    rd(8'h40, 32'h0, "unmapped");
    $display("test setup done");
    // four-beat write, address rewritten while busy must be ignored
    wb(OFS_ADDR, 1'b1, 32'h1000);
    wb(OFS_BURST, 1'b1, 32'h5a03);
    wb(OFS_PAT, 1'b1, 32'hc3a50f1e);
    wb(OFS_STRB, 1'b1, 32'h0f0ff0f0);
    wb(OFS_CTRL, 1'b1, 32'h157);
    chk("req", {pres, dir, addr, tag, len}, {2'b11, 32'h1000, 16'h5a03});
    chk("req_ctl", {bt, bsz, atom}, {2'h1, 3'h5, 2'h1});
    wb(OFS_ADDR, 1'b1, 32'h2000);
    idle();
    rd(OFS_ADDR, 32'h1000, "busy_write");
    rd(OFS_STAT, 32'h5a02, "wr_status");
    chk("beats", beats, 8'h4);
    chk("wdata", wdata, {8{32'hc3a50f1e}});
    chk("wstrb_wid", {wstrb, wid}, {32'h0f0ff0f0, 8'h5a});
    $display("test write done");
    // three-beat reads, every status code
    for (int r = 0; r < 4; r++)
    begin
      wb(OFS_STAT, 1'b1, 32'h6);
      rsp <= r[1:0];
      wb(OFS_BURST, 1'b1, 32'h3302);
      wb(OFS_CTRL, 1'b1, 32'h1);
      idle();
      rd(OFS_STAT, {14'h0, r[1:0], 8'h33, 5'h0, r != 0, 2'h2}, "rd_status");
      rd(OFS_RDAT, 32'ha5a50002, "rd_data");
    end
    $display("test read done");
    // corrupted tags from the target must raise the error flag
    fault <= 1'b1;
    rsp <= 2'h0;
    wb(OFS_STAT, 1'b1, 32'h6);
    wb(OFS_BURST, 1'b1, 32'h5a00);
    wb(OFS_CTRL, 1'b1, 32'h3);
    idle();
    rd(OFS_STAT, 32'ha506, "wr_bad_tag");
    chk("one_beat", beats, 8'h1);
    wb(OFS_STAT, 1'b1, 32'h6);
    wb(OFS_BURST, 1'b1, 32'h3300);
    wb(OFS_CTRL, 1'b1, 32'h1);
    idle();
    rd(OFS_STAT, 32'hcc06, "rd_bad_tag");
    rd(OFS_RDAT, 32'ha5a50000, "rd_one");
    fault <= 1'b0;
    $display("test fault done");
    // one byte lane only, then a reset in mid-run
    bsel = 4'h2;
    wb(OFS_PAT, 1'b1, 32'h00007700);
    bsel = 4'hf;
    rd(OFS_PAT, 32'hc3a5771e, "pat_lane");
    RESET <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RESET <= 1'b0;
    chk("pins_rerst", {srst, sgo, mrn, pres}, 4'b1000);
    rd(OFS_STAT, 32'h0, "stat_rerst");
    rd(OFS_PAT, 32'h0, "pat_rerst");
    $display("test reset done");
    summarize();
  end
endmodule : tb
`default_nettype wire
